// *** include/result_status_pkg.sv ***
// Package: result status byte layout, reset sources and block timing
package result_status_pkg;

    localparam int BYTE_W = 8;

    // Termination codes
    localparam logic [1:0] TERM_NORMAL   = 2'h0;
    localparam logic [1:0] TERM_ABNORMAL = 2'h1;
    localparam logic [1:0] TERM_INVALID  = 2'h2;
    localparam logic [1:0] TERM_POLLING  = 2'h3;

    // Result byte indices
    localparam logic [2:0] IDX_ST0 = 3'h0;
    localparam logic [2:0] IDX_ST1 = 3'h1;
    localparam logic [2:0] IDX_ST2 = 3'h2;
    localparam logic [2:0] IDX_ST3 = 3'h3;

    // Status byte 0 fields
    localparam int ST0_TERM_HI  = 7;
    localparam int ST0_TERM_LO  = 6;
    localparam int ST0_POS_FIN  = 5;
    localparam int ST0_EQ_FAULT = 4;
    localparam int ST0_ZERO     = 3;
    localparam int ST0_HEAD     = 2;

    // Status byte 1 fields
    localparam int ST1_END_TRACK = 7;
    localparam int ST1_ZERO_HI   = 6;
    localparam int ST1_CRC_ANY   = 5;
    localparam int ST1_OVERRUN   = 4;
    localparam int ST1_ZERO_LO   = 3;
    localparam int ST1_MISSING   = 2;
    localparam int ST1_WR_BLOCK  = 1;
    localparam int ST1_ID_SYNC   = 0;

    // Status byte 2 fields
    localparam int ST2_ZERO_HI   = 7;
    localparam int ST2_CTRL_MARK = 6;
    localparam int ST2_CRC_PAY   = 5;
    localparam int ST2_TRK_MIS   = 4;
    localparam int ST2_ZERO_B3   = 3;
    localparam int ST2_ZERO_B2   = 2;
    localparam int ST2_BAD_TRK   = 1;
    localparam int ST2_PAY_SYNC  = 0;

    // Status byte 3 fields
    localparam int ST3_ZERO      = 7;
    localparam int ST3_WPROT     = 6;
    localparam int ST3_ONE_HI    = 5;
    localparam int ST3_TRACK_ZERO_INPUT      = 4;
    localparam int ST3_ONE_LO    = 3;
    localparam int ST3_HEAD      = 2;

    // Positioning limits
    localparam logic [7:0] RECAL_STEP_LIMIT = 8'h50;
    localparam logic [7:0] BAD_TRACK_ID     = 8'hff;
    localparam logic [7:0] LAST_SECTOR      = 8'hff;

    // Power-on reset stretch
    localparam int POR_TIME_NS = 100;
    localparam int CLK_NS      = 10;
    localparam int POR_CYCLES  = (POR_TIME_NS + CLK_NS - 1) / CLK_NS;

endpackage

// *** rtl/reset_gen.sv ***
// Reset combiner: pin, output-register, rate-select and power-on sources
`timescale 1ns/1ps
module reset_gen
    import result_status_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic reset_pin_in,
    input  wire logic dor_reset_wr,
    input  wire logic dor_reset_val,
    input  wire logic rate_reset_wr,
    output logic      core_reset,
    output logic      pin_reset,
    output logic      dor_reset_bit
);
    typedef struct packed {
        logic       pin_m;
        logic       pin_s;
        logic [3:0] por_cnt;
        logic       dor_bit;
        logic       rate_pulse;
        logic       core;
        logic       pin;
    } rg_state_t;

    rg_state_t s_reg;
    rg_state_t s_next;

    always_comb begin
        s_next       = s_reg;
        s_next.pin_m = reset_pin_in;
        s_next.pin_s = s_reg.pin_m;
        if (s_reg.por_cnt != 4'h0) begin
            s_next.por_cnt = s_reg.por_cnt - 4'h1;
        end
        // Output-register bit set by pin reset, held until host clears it
        if (s_reg.pin_s || s_reg.por_cnt != 4'h0) begin
            s_next.dor_bit = 1'b1;
        end else if (dor_reset_wr) begin
            s_next.dor_bit = dor_reset_val;
        end
        // Rate-select reset clears itself after one cycle
        s_next.rate_pulse = rate_reset_wr;
        s_next.pin        = s_reg.pin_s || (s_reg.por_cnt != 4'h0);
        s_next.core       = s_next.pin || s_next.dor_bit || s_next.rate_pulse;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_reg         <= '0;
            s_reg.por_cnt <= 4'(POR_CYCLES);
            s_reg.dor_bit <= 1'b1;
            s_reg.core    <= 1'b1;
            s_reg.pin     <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign core_reset    = s_reg.core;
    assign pin_reset     = s_reg.pin;
    assign dor_reset_bit = s_reg.dor_bit;

    a_dor_sticky: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(dor_reset_bit) |-> $past(dor_reset_wr) && !$past(dor_reset_val)) else $error("dor bit fell alone");
    a_rate_core: assert property (@(posedge clk_sys) disable iff (rst)
        rate_reset_wr |=> core_reset) else $error("rate reset missed");

endmodule // reset_gen

// *** rtl/result_status.sv ***
// Result status bytes builder with reset handling
//
// Function
// - Status bytes are read one after another through the data register.
// - Byte 0 bits 7:6 carry the two-bit termination code.
// - Byte 0 bit 5 set when seek, relative seek or recalibrate finishes.
// - Byte 0 bit 4 set after 80 fruitless recalibrate steps or outward overstep.
// - Byte 0 bit 3 zero, bit 2 head, bits 1:0 selected drive.
// - Byte 1 bit 7 on access to sector 255 or no terminal count.
// - Byte 1 bit 5 on any CRC fault, identifier or data field.
// - Byte 1 bit 4 on service overrun or underrun.
// - Byte 1 bit 2 when sector missing, bad identifier or wrong sequence.
// - Byte 1 bit 1 when write protect rises during write or format.
// - Byte 1 bit 0 when identifier or data address mark absent.
// - Byte 2 bit 6 on control mark mismatch; bits 7,3,2 read zero.
// - Byte 2 bit 5 on data field CRC fault.
// - Byte 2 bit 4 when identifier track differs from internal track.
// - Byte 2 bit 1 when differing identifier track equals ff hex.
// - Byte 2 bit 0 when no data or deleted data mark found.
// - Byte 3 shows live pins; bits 5,3 one, bit 7 zero.
// - Reset from pin, output register bit, rate bit, power-on; exits power-down.
// - Any reset aborts operations and returns the block idle.
// - Leaving reset clears configure settings; polling enabled by default.
// - Rate reset self clears; output-register reset sticky and dominant.
// - Pin reset clears all but specify timing values.
`timescale 1ns/1ps
module result_status
    import result_status_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // Reset sources
    input  wire logic              reset_pin_in,
    input  wire logic              dor_reset_wr,
    input  wire logic              dor_reset_val,
    input  wire logic              rate_reset_wr,
    // Configure and specify writes
    input  wire logic              cfg_wr,
    input  wire logic              cfg_poll_disable,
    input  wire logic              spec_wr,
    input  wire logic [7:0]        spec_value,
    // Drive cable pins
    input  wire logic              write_protect_input,
    input  wire logic              track_zero_input,
    // Drive selection from command logic
    input  wire logic              head_sel_in,
    input  wire logic [1:0]        drive_sel_in,
    // Command engine events
    input  wire logic              cmd_done,
    input  wire logic              cmd_invalid,
    input  wire logic              cmd_polling,
    input  wire logic              cmd_is_write,
    input  wire logic              cmd_is_read_del,
    input  wire logic              cmd_sense_drive,
    input  wire logic              seek_done,
    input  wire logic              recal_step,
    input  wire logic              recal_active,
    input  wire logic              rel_seek_underflow,
    input  wire logic [7:0]        sector_number,
    input  wire logic              terminal_count_input,
    input  wire logic              id_crc_fault,
    input  wire logic              data_crc_fault,
    input  wire logic              service_late,
    input  wire logic              sector_not_found,
    input  wire logic              id_sync_miss,
    input  wire logic              payload_sync_miss,
    input  wire logic              deleted_mark_seen,
    input  wire logic              normal_mark_seen,
    input  wire logic              id_track_valid,
    input  wire logic [7:0]        id_track,
    input  wire logic [7:0]        internal_track,
    // Data register read
    input  wire logic              data_rd,
    output logic [7:0]             data_out,
    output logic                   result_ready,
    output logic                   core_busy,
    output logic                   head_select_output,
    output logic                   drive_select_out0,
    output logic                   drive_select_out1,
    output logic                   poll_enable,
    output logic                   power_down_exit,
    output logic [7:0]             spec_timing,
    output logic                   dor_reset_state
);
    // ==========================================================
    // State
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_BUSY   = 3'b010,
        ST_RESULT = 3'b100
    } phase_t;

    typedef struct packed {
        phase_t     phase;
        logic [1:0] term;
        logic       pos_fin;
        logic       eq_fault;
        logic       end_track;
        logic       crc_any;
        logic       overrun;
        logic       missing;
        logic       wr_block;
        logic       id_sync;
        logic       ctrl_mark;
        logic       crc_pay;
        logic       trk_mis;
        logic       bad_trk;
        logic       pay_sync;
        logic [6:0] step_cnt;
        logic [7:0] hold0;
        logic [7:0] hold1;
        logic [7:0] hold2;
        logic [2:0] rd_idx;
        logic [2:0] rd_last;
        logic [7:0] dout;
        logic       ready;
        logic       head;
        logic [1:0] drv;
        logic       poll;
        logic       pd_exit;
        logic       wp_m;
        logic       wp_s;
        logic       wp_d;
        logic       t0_m;
        logic       t0_s;
    } rs_state_t;

    rs_state_t  s_reg;
    rs_state_t  s_next;
    logic [7:0] spec_reg;
    logic       core_reset;
    logic       pin_reset;
    logic       dor_bit;

    // ==========================================================
    // Reset sources
    reset_gen u_reset (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .reset_pin_in  (reset_pin_in),
        .dor_reset_wr  (dor_reset_wr),
        .dor_reset_val (dor_reset_val),
        .rate_reset_wr (rate_reset_wr),
        .core_reset    (core_reset),
        .pin_reset     (pin_reset),
        .dor_reset_bit (dor_bit)
    );

    function automatic logic [7:0] byte3(input logic wp, input logic t0, input logic hd, input logic [1:0] ds);
        logic [7:0] b;
        b             = 8'h00;
        b[ST3_ZERO]   = 1'b0;
        b[ST3_WPROT]  = wp;
        b[ST3_ONE_HI] = 1'b1;
        b[ST3_TRACK_ZERO_INPUT]   = t0;
        b[ST3_ONE_LO] = 1'b1;
        b[ST3_HEAD]   = hd;
        b[1:0]        = ds;
        return b;
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        s_next      = s_reg;
        s_next.wp_m = write_protect_input;
        s_next.wp_s = s_reg.wp_m;
        s_next.wp_d = s_reg.wp_s;
        s_next.t0_m = track_zero_input;
        s_next.t0_s = s_reg.t0_m;
        s_next.pd_exit = 1'b0;
        if (cfg_wr) begin
            s_next.poll = !cfg_poll_disable;
        end
        case (s_reg.phase)
            ST_IDLE: begin
                s_next.head = head_sel_in;
                s_next.drv  = drive_sel_in;
                if (!cmd_done) begin
                    s_next.phase    = ST_BUSY;
                    s_next.step_cnt = 7'h00;
                    {s_next.pos_fin, s_next.eq_fault, s_next.end_track, s_next.crc_any} = 4'h0;
                    {s_next.overrun, s_next.missing, s_next.wr_block, s_next.id_sync} = 4'h0;
                    {s_next.ctrl_mark, s_next.crc_pay, s_next.trk_mis} = 3'h0;
                    {s_next.bad_trk, s_next.pay_sync} = 2'h0;
                end
            end
            ST_BUSY: begin
                s_next.head = head_sel_in;
                s_next.drv  = drive_sel_in;
                if (seek_done) s_next.pos_fin = 1'b1;
                if (recal_active && recal_step && !s_reg.t0_s) begin
                    s_next.step_cnt = s_reg.step_cnt + 7'h01;
                    if (s_reg.step_cnt + 7'h01 >= RECAL_STEP_LIMIT[6:0]) s_next.eq_fault = 1'b1;
                end
                if (rel_seek_underflow) s_next.eq_fault = 1'b1;
                if (sector_number == LAST_SECTOR || (cmd_done && !terminal_count_input)) s_next.end_track = 1'b1;
                if (id_crc_fault || data_crc_fault) s_next.crc_any = 1'b1;
                if (data_crc_fault) s_next.crc_pay = 1'b1;
                if (service_late) s_next.overrun = 1'b1;
                if (sector_not_found) s_next.missing = 1'b1;
                if (cmd_is_write && s_reg.wp_s && !s_reg.wp_d) s_next.wr_block = 1'b1;
                if (id_sync_miss || payload_sync_miss) s_next.id_sync = 1'b1;
                if (payload_sync_miss) s_next.pay_sync = 1'b1;
                if ((deleted_mark_seen && !cmd_is_read_del) || (normal_mark_seen && cmd_is_read_del)) begin
                    s_next.ctrl_mark = 1'b1;
                end
                if (id_track_valid && id_track != internal_track) begin
                    s_next.trk_mis = 1'b1;
                    if (id_track == BAD_TRACK_ID) s_next.bad_trk = 1'b1;
                end
                if (cmd_done) begin
                    s_next.phase = ST_RESULT;
                    if (cmd_invalid)      s_next.term = TERM_INVALID;
                    else if (cmd_polling) s_next.term = TERM_POLLING;
                    else if (s_next.eq_fault || s_next.end_track || s_next.crc_any || s_next.overrun
                             || s_next.missing || s_next.wr_block || s_next.id_sync || s_next.ctrl_mark
                             || s_next.crc_pay || s_next.trk_mis || s_next.bad_trk || s_next.pay_sync)
                        s_next.term = TERM_ABNORMAL;
                    else                  s_next.term = TERM_NORMAL;
                    // Freeze status bytes at termination
                    s_next.hold0 = {s_next.term, s_next.pos_fin, s_next.eq_fault, 1'b0, head_sel_in,
                                    drive_sel_in};
                    s_next.hold1 = {s_next.end_track, 1'b0, s_next.crc_any, s_next.overrun, 1'b0,
                                    s_next.missing, s_next.wr_block, s_next.id_sync};
                    s_next.hold2 = {1'b0, s_next.ctrl_mark, s_next.crc_pay, s_next.trk_mis, 2'h0,
                                    s_next.bad_trk, s_next.pay_sync};
                    s_next.rd_idx  = cmd_sense_drive ? IDX_ST3 : IDX_ST0;
                    s_next.rd_last = cmd_sense_drive ? IDX_ST3 : IDX_ST2;
                    s_next.ready   = 1'b1;
                    s_next.dout    = cmd_sense_drive
                                   ? byte3(s_reg.wp_s, s_reg.t0_s, head_sel_in, drive_sel_in)
                                   : s_next.hold0;
                end
            end
            ST_RESULT: begin
                if (data_rd) begin
                    if (s_reg.rd_idx == s_reg.rd_last) begin
                        s_next.phase = ST_IDLE;
                        s_next.ready = 1'b0;
                        s_next.dout  = 8'h00;
                    end else begin
                        s_next.rd_idx = s_reg.rd_idx + 3'h1;
                        case (s_reg.rd_idx + 3'h1)
                            IDX_ST1: s_next.dout = s_reg.hold1;
                            IDX_ST2: s_next.dout = s_reg.hold2;
                            default: s_next.dout = s_reg.hold0;
                        endcase
                    end
                end
            end
            default: s_next.phase = ST_IDLE;
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_sys) begin
        if (rst || core_reset) begin
            s_reg         <= '0;
            s_reg.phase   <= ST_IDLE;
            s_reg.poll    <= 1'b1;
            s_reg.pd_exit <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Specify timing survives pin reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            spec_reg <= 8'h00;
        end else if (spec_wr && !core_reset) begin
            spec_reg <= spec_value;
        end
    end

    assign data_out           = s_reg.dout;
    assign result_ready       = s_reg.ready;
    assign core_busy          = s_reg.phase != ST_IDLE;
    assign head_select_output = s_reg.head;
    assign drive_select_out0  = s_reg.drv[0];
    assign drive_select_out1  = s_reg.drv[1];
    assign poll_enable        = s_reg.poll;
    assign power_down_exit    = s_reg.pd_exit;
    assign spec_timing        = spec_reg;
    assign dor_reset_state    = dor_bit;

    // ==========================================================
    // Checks
    a_reset_idle: assert property (@(posedge clk_sys) disable iff (rst)
        core_reset |=> !result_ready && !core_busy) else $error("not idle after reset");
    a_poll_default: assert property (@(posedge clk_sys) disable iff (rst)
        core_reset |=> poll_enable) else $error("polling not restored");
    a_pd_exit: assert property (@(posedge clk_sys) disable iff (rst)
        core_reset |=> power_down_exit) else $error("power-down not left");
    a_hold_stable: assert property (@(posedge clk_sys) disable iff (rst || core_reset)
        result_ready && !data_rd |=> $stable(data_out) || core_reset) else $error("result byte moved");
    a_st1_zero: assert property (@(posedge clk_sys) disable iff (rst)
        result_ready |-> (data_out[ST1_ZERO_HI] == 1'b0 || s_reg.rd_idx != IDX_ST1)) else $error("byte1 bit6 set");
    a_st2_zero: assert property (@(posedge clk_sys) disable iff (rst)
        result_ready && s_reg.rd_idx == IDX_ST2 |-> data_out[ST2_ZERO_HI] == 1'b0
        && data_out[ST2_ZERO_B3:ST2_ZERO_B2] == 2'h0) else $error("byte2 zero bits set");
    a_st3_fixed: assert property (@(posedge clk_sys) disable iff (rst)
        result_ready && s_reg.rd_idx == IDX_ST3 |-> data_out[ST3_ONE_HI] && data_out[ST3_ONE_LO]
        && !data_out[ST3_ZERO]) else $error("byte3 fixed bits wrong");
    a_st0_zero: assert property (@(posedge clk_sys) disable iff (rst)
        result_ready && s_reg.rd_idx == IDX_ST0 |-> !data_out[ST0_ZERO]) else $error("byte0 bit3 set");
    a_invalid_code: assert property (@(posedge clk_sys) disable iff (rst || core_reset)
        s_reg.phase == ST_BUSY && cmd_done && cmd_invalid && !cmd_sense_drive
        |=> data_out[ST0_TERM_HI:ST0_TERM_LO] == TERM_INVALID) else $error("invalid code wrong");

endmodule // result_status

// *** verification/result_host_model.sv ***
// Host model that reads result bytes from the data register
`timescale 1ns/1ps
module result_host_model (
    input  wire logic       clk_sys,
    input  wire logic       clr,
    input  wire logic [1:0] gap,
    input  wire logic       result_ready,
    input  wire logic [7:0] data_out,
    output logic            data_rd,
    output logic [7:0]      rx [4],
    output int              count
);
    int wait_cnt;
    initial begin
        data_rd  = 1'b0;
        count    = 0;
        wait_cnt = 0;
    end
    // Take the byte at the sampling edge, then pace the next read
    always @(posedge clk_sys) begin
        if (clr) begin
            count = 0;
        end else if (data_rd) begin
            rx[count[1:0]] = data_out;
            count = count + 1;
            wait_cnt = int'(gap);
        end
        #1;
        if (result_ready === 1'b1 && wait_cnt == 0) begin
            data_rd = 1'b1;
        end else begin
            data_rd = 1'b0;
            if (wait_cnt != 0) wait_cnt = wait_cnt - 1;
        end
    end
endmodule // result_host_model

// *** verification/disk_ctrl_result_status_and_reset_tb.sv ***
// Testbench for the result status builder
`timescale 1ns/1ps
module disk_ctrl_result_status_and_reset_tb;
    import result_status_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic reset_pin_in, dor_reset_wr, dor_reset_val, rate_reset_wr, cfg_wr, cfg_poll_disable, spec_wr;
    logic write_protect_input, track_zero_input, head_sel_in, cmd_done, cmd_invalid, cmd_polling;
    logic cmd_is_write, cmd_is_read_del, cmd_sense_drive, seek_done, recal_step, recal_active;
    logic rel_seek_underflow, terminal_count_input, id_crc_fault, data_crc_fault, service_late;
    logic sector_not_found, id_sync_miss, payload_sync_miss, deleted_mark_seen, normal_mark_seen;
    logic id_track_valid, data_rd, result_ready, core_busy, head_select_output, clr, pde;
    logic drive_select_out0, drive_select_out1, poll_enable, power_down_exit, dor_reset_state;
    logic [1:0] drive_sel_in, gap;
    logic [7:0] spec_value, sector_number, id_track, internal_track, data_out, spec_timing, rx [4];
    int count, fail_count, num_checks, seed;
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (power_down_exit === 1'b1) pde <= 1'b1;
    result_status u_result_status (.*);
    result_host_model u_result_host_model (.clk_sys(clk_sys), .clr(clr), .gap(gap), .result_ready(result_ready),
        .data_out(data_out), .data_rd(data_rd), .rx(rx), .count(count));
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic check(input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic wait_busy(input logic want);
        int i;
        for (i = 0; i < 60 && core_busy !== want; i++) tick(1);
        if (core_busy !== want) begin
            fail_count++;
            end_sim();
        end
    endtask
    task automatic clr_ev();
        {seek_done, recal_step, rel_seek_underflow, id_crc_fault, data_crc_fault, service_late} = '0;
        {sector_not_found, id_sync_miss, payload_sync_miss, deleted_mark_seen, normal_mark_seen} = '0;
        {id_track_valid, cmd_done, cmd_invalid, cmd_polling, cmd_sense_drive, clr} = '0;
        sector_number = 8'h00;
        id_track = internal_track;
    endtask
    // Expected bytes 0, 1 and 2 for an event code
    function automatic logic [23:0] exp_res(input int ev);
        logic [7:0] s1, s2;
        logic [1:0] tc;
        logic se, ec;
        {s1, s2, se, ec} = '0;
        case (ev)
            1: se = 1'b1;
            2, 17: ec = 1'b1;
            3: s1[ST1_CRC_ANY] = 1'b1;
            4: {s1[ST1_CRC_ANY], s2[ST2_CRC_PAY]} = 2'h3;
            5: s1[ST1_OVERRUN] = 1'b1;
            6: s1[ST1_MISSING] = 1'b1;
            7: s1[ST1_ID_SYNC] = 1'b1;
            8: {s1[ST1_ID_SYNC], s2[ST2_PAY_SYNC]} = 2'h3;
            9, 10: s2[ST2_CTRL_MARK] = 1'b1;
            11: s2[ST2_TRK_MIS] = 1'b1;
            12: {s2[ST2_TRK_MIS], s2[ST2_BAD_TRK]} = 2'h3;
            13: s1[ST1_END_TRACK] = 1'b1;
            16: s1[ST1_WR_BLOCK] = 1'b1;
            default: ;
        endcase
        tc = (ec || s1 != 8'h00 || s2 != 8'h00) ? TERM_ABNORMAL : TERM_NORMAL;
        if (ev == 14) tc = TERM_INVALID;
        if (ev == 15) tc = TERM_POLLING;
        return {tc, se, ec, 1'b0, head_sel_in, drive_sel_in, s1, s2};
    endfunction
    task automatic run_cmd(input int ev, input logic sense);
        int i;
        logic [23:0] e;
        wait_busy(1'b1);
        {head_sel_in, drive_sel_in, gap} = $random(seed);
        {write_protect_input, track_zero_input} = (ev >= 16) ? 2'h1 : $random(seed);
        internal_track = $random(seed) & 8'h7f;
        cmd_is_read_del = (ev == 10);
        cmd_is_write = (ev == 16);
        clr_ev();
        tick(4);
        if (ev == 16) begin
            write_protect_input = 1'b1;
            tick(4);
        end else if (ev == 17) begin
            recal_active = 1'b1;
            track_zero_input = 1'b0;
            tick(2);
            for (i = 0; i < 80; i++) begin
                recal_step = 1'b1;
                tick(1);
                recal_step = 1'b0;
                tick(1);
            end
            recal_active = 1'b0;
        end else begin
            case (ev)
                0: id_track_valid = 1'b1;
                1: seek_done = 1'b1;
                2: rel_seek_underflow = 1'b1;
                3: id_crc_fault = 1'b1;
                4: data_crc_fault = 1'b1;
                5: service_late = 1'b1;
                6: sector_not_found = 1'b1;
                7: id_sync_miss = 1'b1;
                8: payload_sync_miss = 1'b1;
                9: deleted_mark_seen = 1'b1;
                10: normal_mark_seen = 1'b1;
                11: {id_track_valid, id_track} = {1'b1, internal_track ^ 8'h01};
                12: {id_track_valid, id_track} = {1'b1, BAD_TRACK_ID};
                13: sector_number = LAST_SECTOR;
                default: ;
            endcase
            tick(1);
            clr_ev();
        end
        tick(2);
        {cmd_done, clr, cmd_sense_drive} = {2'h3, sense};
        cmd_invalid = (ev == 14);
        cmd_polling = (ev == 15);
        tick(1);
        clr_ev();
        for (i = 0; i < 40 && count < (sense ? 1 : 3); i++) tick(1);
        check(8'h00, result_ready);
        e = exp_res(ev);
        if (sense) begin
            check({1'b0, write_protect_input, 1'b1, track_zero_input, 1'b1, head_sel_in, drive_sel_in}, rx[0]);
            check({6'h00, drive_select_out1, drive_select_out0}, {6'h00, drive_sel_in});
        end else begin
            check(e[23:16], rx[0]);
            check(e[15:8], rx[1]);
            check(e[7:0], rx[2]);
        end
        cmd_is_write = 1'b0;
    endtask
    task automatic soft_reset(input logic use_dor);
        pde = 1'b0;
        id_crc_fault = 1'b0;
        {dor_reset_wr, dor_reset_val, rate_reset_wr} = {use_dor, use_dor, ~use_dor};
        tick(1);
        {dor_reset_wr, rate_reset_wr} = 2'h0;
        tick(1);
        check(8'h00, {core_busy, result_ready});
    endtask
    initial begin
        seed = 56;
        {reset_pin_in, dor_reset_wr, dor_reset_val, rate_reset_wr, cfg_wr, cfg_poll_disable, spec_wr} = '0;
        {write_protect_input, track_zero_input, head_sel_in, drive_sel_in, gap, recal_active} = '0;
        {spec_value, internal_track, cmd_is_write, cmd_is_read_del, pde} = '0;
        terminal_count_input = 1'b1;
        clr_ev();
        tick(16);
        rst = 1'b0;
        tick(12);
        check(8'h01, {core_busy, dor_reset_state});
        dor_reset_wr = 1'b1;
        tick(1);
        dor_reset_wr = 1'b0;
        for (int k = 0; k < 18; k++) run_cmd(k, 1'b0);
        run_cmd(0, 1'b1);
        for (int k = 0; k < 40; k++) run_cmd(int'($unsigned($random(seed)) % 19), k[0]);
        {cfg_wr, cfg_poll_disable, spec_wr, spec_value} = {3'h7, 8'(unsigned'($random(seed)))};
        tick(1);
        {cfg_wr, spec_wr} = 2'h0;
        tick(1);
        check(8'h00, poll_enable);
        wait_busy(1'b1);
        id_crc_fault = 1'b1;
        tick(1);
        soft_reset(1'b0);
        wait_busy(1'b1);
        check(8'h0d, {pde, poll_enable, dor_reset_state, spec_timing == spec_value});
        run_cmd(0, 1'b0);
        reset_pin_in = 1'b1;
        tick(4);
        reset_pin_in = 1'b0;
        tick(20);
        check(8'h07, {core_busy, dor_reset_state, poll_enable, spec_timing == spec_value});
        soft_reset(1'b0);
        check(8'h01, dor_reset_state);
        dor_reset_wr = 1'b1;
        tick(1);
        dor_reset_wr = 1'b0;
        run_cmd(3, 1'b0);
        soft_reset(1'b1);
        check(8'h01, dor_reset_state);
        {dor_reset_wr, dor_reset_val} = 2'h2;
        tick(1);
        dor_reset_wr = 1'b0;
        run_cmd(9, 1'b0);
        end_sim();
    end
endmodule // disk_ctrl_result_status_and_reset_tb
